// ---- logic/pcdt_pkg.sv ----
// Purpose: Shared constants for the PLL clock divider tree
// Assumes: Core clock mclk_i at 40 MHz stands in for the PLL VCO output
// Notes: Divisor codes select powers of two for the frequency-select divisor
package pcdt_pkg;
    localparam int PCDT_REF_OSC_KHZ = 29491;
    localparam int PCDT_USB_REF_MHZ = 48;
    localparam int PCDT_CLK_PERIOD_NS = 25;
    localparam int PCDT_SETTLE_NS = 4000000;
    localparam int PCDT_SETTLE_CYC = PCDT_SETTLE_NS / PCDT_CLK_PERIOD_NS;
    localparam int PCDT_INIT_CYC = 3;
    localparam int PCDT_SWRST_CYC = 128;
    localparam int PCDT_MULT_W = 5;
    localparam int PCDT_FS_W = 2;
    localparam int PCDT_WEIGHT_W = 9;
    localparam int PCDT_CNT_W = 20;
    localparam logic [1:0] PCDT_FS_RESET = 2'h0;
    localparam int PCDT_CPU_BIT = 0;
    localparam int PCDT_HCLK_BIT = 1;
    localparam int PCDT_BBUS_BIT = 2;
    localparam int PCDT_EXT_PCI = 0;
    localparam int PCDT_EXT_LCD = 1;
    localparam int PCDT_EXT_SER = 2;
    localparam int PCDT_EXT_PAR = 3;
    localparam int PCDT_EXT_RX = 4;
    localparam int PCDT_EXT_TX = 5;
    localparam int PCDT_EXT_N = 6;
    typedef enum logic [1:0] {
        PCDT_ST_INIT = 2'b00,
        PCDT_ST_RUN = 2'b01,
        PCDT_ST_SETTLE = 2'b10,
        PCDT_ST_SWRST = 2'b11
    } pcdt_state_t;
endpackage

// ---- logic/pcdt_edge_sync.sv ----
// Purpose: Bring an outside clock pin into mclk_i and flag its rising edges
// Assumes: Pin runs well below half of mclk_i
// Notes: First stage feeds only the second stage
module pcdt_edge_sync
    import pcdt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic rise_o
);
    logic meta;
    logic stable;
    logic prev;
    logic next_rise;

    always_comb begin
        next_rise = stable & ~prev;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta <= pin_i;
            stable <= meta;
            prev <= stable;
            rise_o <= next_rise;
        end
    end
endmodule

// ---- logic/pcdt_clock_tree.sv ----
// Purpose: PLL setting control, settle-and-reset sequence and clock enable tree
// Assumes: mclk_i is the VCO-rate clock; every derived clock is a one-cycle enable
// Notes: Settings requests and divider selects come from logic in the mclk_i domain
// Behaviour
// - System clocks derive through the PLL from an external reference oscillator.
// - VCO equals reference times multiplier field plus one, over divisor.
// - Processor clock VCO/2, main bus VCO/4, peripheral bus VCO/8.
// - PCI clock is VCO divided by 14, 12, 10 or 8.
// - LCD clock is VCO divided by 4, 8, 16 or 32.
// - Settings load at power-up; software changes limited to max down to half.
// - After a settings change, wait about 4 ms, then reset the system.
// - Clocks go to CPU, buses, PCI, LCD, timers, memory, serial and parallel.
// - MAC clocks come from PHY; RMII uses receive clock, transmit tied low.
// - PCI, LCD, serial and parallel modules may use an external clock.
// - USB runs from its own PLL fed by 48 MHz crystal or oscillator.
// - Five-bit multiplier is sampled from strap pins at power-up.
// - Writing one to the software-change bit resets the system.
module pcdt_clock_tree
    import pcdt_pkg::*;
#(
    parameter int SETTLE_CYCLES = PCDT_SETTLE_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [4:0] strap_mult_i,
    input wire logic sw_change_i,
    input wire logic [4:0] sw_mult_i,
    input wire logic [1:0] sw_fs_i,
    input wire logic sw_sys_reset_i,
    input wire logic [1:0] pci_div_sel_i,
    input wire logic [1:0] lcd_div_sel_i,
    input wire logic [3:0] ext_sel_i,
    input wire logic [3:0] ext_clk_i,
    input wire logic rmii_mode_i,
    input wire logic rx_clk_i,
    input wire logic tx_clk_i,
    input wire logic usb_osc_direct_i,
    output logic [4:0] pll_multiplier_field_o,
    output logic [1:0] pll_freq_select_divisor_o,
    output logic cpu_en_o,
    output logic hclk_en_o,
    output logic bbus_en_o,
    output logic pci_en_o,
    output logic lcd_en_o,
    output logic ser_en_o,
    output logic par_en_o,
    output logic mac_rx_en_o,
    output logic mac_tx_en_o,
    output logic usb_pll_bypass_o,
    output logic sys_reset_n_o,
    output logic change_refused_o
);
    // Relative VCO rate at a fixed reference: (mult + 1) / 2^fs, scaled by 8
    function automatic logic [8:0] vco_weight(input logic [4:0] m, input logic [1:0] fs);
        logic [8:0] w;
        w = {4'h0, m} + 9'h001;
        vco_weight = (w << 3) >> fs;
    endfunction

    function automatic logic [4:0] pci_last(input logic [1:0] sel);
        case (sel)
            2'h0: pci_last = 5'h0D;
            2'h1: pci_last = 5'h0B;
            2'h2: pci_last = 5'h09;
            default: pci_last = 5'h07;
        endcase
    endfunction

    logic rst_meta;
    logic rst_n;
    logic [PCDT_EXT_N-1:0] pin_rise;
    logic [PCDT_EXT_N-1:0] pins;
    pcdt_state_t state, next_state;
    logic [PCDT_CNT_W-1:0] cnt, next_cnt;
    logic [4:0] mult, next_mult;
    logic [1:0] fs, next_fs;
    logic [8:0] max_w, next_max_w;
    logic refused, next_refused;
    logic sys_rst_n, next_sys_rst_n;
    logic [2:0] chain, next_chain;
    logic [4:0] pci_cnt, next_pci_cnt;
    logic [4:0] lcd_cnt, next_lcd_cnt;
    logic [9:0] en, next_en;
    logic [8:0] req_w;

    // Reset release is synchronised so every flop leaves reset at one edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign pins = {tx_clk_i, rx_clk_i, ext_clk_i};

    genvar g;
    generate
        for (g = 0; g < PCDT_EXT_N; g++) begin : g_pin
            pcdt_edge_sync u_sync (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n),
                .pin_i(pins[g]),
                .rise_o(pin_rise[g])
            );
        end
    endgenerate

    // Strap pins are quasi-static; double sampled before capture
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= 5'h00;
            strap_sync <= 5'h00;
        end else begin
            strap_meta <= strap_mult_i;
            strap_sync <= strap_meta;
        end
    end

    always_comb begin
        req_w = vco_weight(sw_mult_i, sw_fs_i);
        next_state = state;
        next_cnt = cnt;
        next_mult = mult;
        next_fs = fs;
        next_max_w = max_w;
        next_refused = 1'b0;
        next_sys_rst_n = 1'b0;
        case (state)
            PCDT_ST_INIT: begin
                next_cnt = cnt + 20'h00001;
                if (cnt == PCDT_CNT_W'(PCDT_INIT_CYC)) begin
                    next_mult = strap_sync;
                    next_fs = PCDT_FS_RESET;
                    next_max_w = vco_weight(strap_sync, PCDT_FS_RESET);
                    next_cnt = '0;
                    next_state = PCDT_ST_SETTLE;
                end
            end
            PCDT_ST_RUN: begin
                next_sys_rst_n = 1'b1;
                if (sw_change_i) begin
                    // Only max rate down to half of it is accepted
                    if (req_w <= max_w && {req_w, 1'b0} >= {1'b0, max_w}) begin
                        next_mult = sw_mult_i;
                        next_fs = sw_fs_i;
                        next_cnt = '0;
                        next_sys_rst_n = 1'b0;
                        next_state = PCDT_ST_SETTLE;
                    end else begin
                        next_refused = 1'b1;
                    end
                end else if (sw_sys_reset_i) begin
                    next_cnt = '0;
                    next_sys_rst_n = 1'b0;
                    next_state = PCDT_ST_SWRST;
                end
            end
            PCDT_ST_SETTLE: begin
                next_cnt = cnt + 20'h00001;
                if (cnt >= PCDT_CNT_W'(SETTLE_CYCLES - 1)) begin
                    next_cnt = '0;
                    next_sys_rst_n = 1'b1;
                    next_state = PCDT_ST_RUN;
                end
            end
            PCDT_ST_SWRST: begin
                next_cnt = cnt + 20'h00001;
                if (cnt >= PCDT_CNT_W'(PCDT_SWRST_CYC - 1)) begin
                    next_cnt = '0;
                    next_sys_rst_n = 1'b1;
                    next_state = PCDT_ST_RUN;
                end
            end
            default: begin
                next_cnt = '0;
                next_state = PCDT_ST_INIT;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= PCDT_ST_INIT;
            cnt <= '0;
            mult <= 5'h00;
            fs <= 2'h0;
            max_w <= 9'h000;
            refused <= 1'b0;
            sys_rst_n <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            mult <= next_mult;
            fs <= next_fs;
            max_w <= next_max_w;
            refused <= next_refused;
            sys_rst_n <= next_sys_rst_n;
        end
    end

    // Dividers run only while the PLL is trusted, so enables stop in reset
    always_comb begin
        next_chain = '0;
        next_pci_cnt = '0;
        next_lcd_cnt = '0;
        next_en = '0;
        if (sys_rst_n) begin
            next_chain = chain + 3'h1;
            next_pci_cnt = (pci_cnt >= pci_last(pci_div_sel_i)) ? 5'h00 : pci_cnt + 5'h01;
            next_lcd_cnt = lcd_cnt + 5'h01;
            next_en[0] = chain[PCDT_CPU_BIT];
            next_en[1] = &chain[PCDT_HCLK_BIT:0];
            next_en[2] = &chain[PCDT_BBUS_BIT:0];
            next_en[3] = ext_sel_i[PCDT_EXT_PCI] ? pin_rise[PCDT_EXT_PCI] :
                         (pci_cnt == pci_last(pci_div_sel_i));
            next_en[4] = ext_sel_i[PCDT_EXT_LCD] ? pin_rise[PCDT_EXT_LCD] :
                         &(lcd_cnt | ~((5'h04 << lcd_div_sel_i) - 5'h01));
            // Serial and parallel modules hang off the peripheral bus rate
            next_en[5] = ext_sel_i[PCDT_EXT_SER] ? pin_rise[PCDT_EXT_SER] : &chain;
            next_en[6] = ext_sel_i[PCDT_EXT_PAR] ? pin_rise[PCDT_EXT_PAR] : &chain;
            next_en[7] = pin_rise[PCDT_EXT_RX];
            // In RMII the transmit pin is tied low, so transmit follows receive
            next_en[8] = rmii_mode_i ? pin_rise[PCDT_EXT_RX] : pin_rise[PCDT_EXT_TX];
        end
        next_en[9] = usb_osc_direct_i;
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            chain <= 3'h0;
            pci_cnt <= 5'h00;
            lcd_cnt <= 5'h00;
            en <= 10'h000;
        end else begin
            chain <= next_chain;
            pci_cnt <= next_pci_cnt;
            lcd_cnt <= next_lcd_cnt;
            en <= next_en;
        end
    end

    // Outputs taken straight from flops
    assign pll_multiplier_field_o = mult;
    assign pll_freq_select_divisor_o = fs;
    assign cpu_en_o = en[0];
    assign hclk_en_o = en[1];
    assign bbus_en_o = en[2];
    assign pci_en_o = en[3];
    assign lcd_en_o = en[4];
    assign ser_en_o = en[5];
    assign par_en_o = en[6];
    assign mac_rx_en_o = en[7];
    assign mac_tx_en_o = en[8];
    assign usb_pll_bypass_o = en[9];
    assign sys_reset_n_o = sys_rst_n;
    assign change_refused_o = refused;
endmodule

// ---- dv/pcdt_clock_tree_sva.sv ----
// Purpose: Port checker for the clock divider tree
// Assumes: Enables are one-cycle pulses in the mclk_i domain
// Notes: Low-time counter stands in for a long repetition
module pcdt_clock_tree_chk #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic sw_change_i,
    input wire logic [4:0] sw_mult_i,
    input wire logic rmii_mode_i,
    input wire logic usb_osc_direct_i,
    input wire logic [4:0] pll_multiplier_field_o,
    input wire logic cpu_en_o,
    input wire logic hclk_en_o,
    input wire logic bbus_en_o,
    input wire logic mac_rx_en_o,
    input wire logic mac_tx_en_o,
    input wire logic usb_pll_bypass_o,
    input wire logic sys_reset_n_o,
    input wire logic change_refused_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int lcnt;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) lcnt <= 0;
        else lcnt <= sys_reset_n_o ? 0 : lcnt + 1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    a_cpu_half: assert property (cpu_en_o |=> !cpu_en_o)
        else $error("cpu enable repeats too soon");
    a_hclk_quarter: assert property (hclk_en_o |=> !hclk_en_o [*3])
        else $error("main bus enable repeats too soon");
    a_bbus_eighth: assert property (bbus_en_o |=> !bbus_en_o [*7])
        else $error("peripheral bus enable repeats too soon");
    a_chain_aligned: assert property ((hclk_en_o || bbus_en_o)
        |-> cpu_en_o && (hclk_en_o || !bbus_en_o))
        else $error("bus enables not aligned");
    a_quiet_reset: assert property (!sys_reset_n_o && !$past(sys_reset_n_o)
        |-> !(cpu_en_o || hclk_en_o || bbus_en_o))
        else $error("enable during system reset");
    a_change_answer: assert property (sw_change_i && sys_reset_n_o
        |=> (!sys_reset_n_o) != change_refused_o)
        else $error("change neither taken nor refused");
    a_field_update: assert property (sw_change_i && sys_reset_n_o ##1 !sys_reset_n_o
        |-> pll_multiplier_field_o == $past(sw_mult_i))
        else $error("multiplier not updated");
    a_refuse_keeps: assert property (change_refused_o
        |-> $stable(pll_multiplier_field_o) && sys_reset_n_o)
        else $error("refused change altered state");
    a_settle_len: assert property ($rose(sys_reset_n_o) |-> lcnt >= SETTLE_CYCLES)
        else $error("system reset released early");
    a_usb_copy: assert property (sys_reset_n_o
        |-> usb_pll_bypass_o == $past(usb_osc_direct_i))
        else $error("usb source select wrong");
    a_rmii_follow: assert property (rmii_mode_i && sys_reset_n_o
        |-> mac_tx_en_o == mac_rx_en_o)
        else $error("transmit enable not from receive clock");
    c_change: cover property (sw_change_i && sys_reset_n_o ##1 !sys_reset_n_o);
    c_refuse: cover property (change_refused_o);
    c_rmii: cover property (rmii_mode_i && mac_tx_en_o);
endmodule
bind pcdt_clock_tree pcdt_clock_tree_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
    .mclk_i, .reset_n_i, .sw_change_i, .sw_mult_i, .rmii_mode_i, .usb_osc_direct_i,
    .pll_multiplier_field_o, .cpu_en_o, .hclk_en_o, .bbus_en_o, .mac_rx_en_o,
    .mac_tx_en_o, .usb_pll_bypass_o, .sys_reset_n_o, .change_refused_o);

// ---- dv/pcdt_phy_model.sv ----
// Purpose: Outside clock sources: PHY clocks and external module clocks
// Assumes: Periods far above mclk_i, unrelated in phase
// Notes: All but the RMII transmit clock run free, like the oscillators they stand for
module pcdt_phy_model (
    input wire logic rmii_i,
    output logic rx_clk_o,
    output logic tx_clk_o,
    output logic [3:0] ext_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tx_run = 1'b0;
    initial rx_clk_o = 1'b0;
    initial ext_clk_o = 4'h0;
    always #510 rx_clk_o = !rx_clk_o;
    always #730 tx_run = !tx_run;
    always #410 ext_clk_o = ~ext_clk_o;
    // RMII board ties the transmit pin low
    assign tx_clk_o = rmii_i ? 1'b0 : tx_run;
endmodule

// ---- dv/test_pcdt_clock_tree.sv ----
// Purpose: Self-checking bench for the clock divider tree
// Assumes: Settle count cut to 20; strap 15 sets the maximum rate
// Notes: Outside clock periods are checked within one cycle of slack
module test_pcdt_clock_tree
    import pcdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 0, reset_n_i = 0, sw_change_i = 0, sw_sys_reset_i = 0;
    logic rmii_mode_i = 0, usb_osc_direct_i = 0, rf;
    logic [4:0] strap_mult_i = 5'h0F, sw_mult_i = 5'h00, pll_multiplier_field_o;
    logic [1:0] sw_fs_i = 2'h0, pci_div_sel_i = 2'h0, lcd_div_sel_i = 2'h0;
    logic [1:0] pll_freq_select_divisor_o;
    logic [3:0] ext_sel_i = 4'h0, ext_clk_i;
    logic rx_clk_i, tx_clk_i, cpu_en_o, hclk_en_o, bbus_en_o, pci_en_o, lcd_en_o;
    logic ser_en_o, par_en_o, mac_rx_en_o, mac_tx_en_o, usb_pll_bypass_o;
    logic sys_reset_n_o, change_refused_o;
    int n_errors = 0, tests_run = 0, cyc = 0, p, lo, em = 15, ef = 0;
    int rows[4][3] = '{'{0, 14, 4}, '{1, 12, 8}, '{2, 10, 16}, '{3, 8, 32}};
    int rqs[6][3] = '{'{7, 0, 1}, '{3, 0, 0}, '{31, 0, 0}, '{15, 1, 1}, '{31, 2, 1},
        '{31, 3, 0}};
    wire [8:0] ens = {mac_tx_en_o, mac_rx_en_o, par_en_o, ser_en_o, lcd_en_o, pci_en_o,
        bbus_en_o, hclk_en_o, cpu_en_o};
    pcdt_clock_tree #(.SETTLE_CYCLES(20)) i_pcdt_clock_tree (.mclk_i, .reset_n_i,
        .strap_mult_i, .sw_change_i, .sw_mult_i, .sw_fs_i, .sw_sys_reset_i, .pci_div_sel_i,
        .lcd_div_sel_i, .ext_sel_i, .ext_clk_i, .rmii_mode_i, .rx_clk_i, .tx_clk_i,
        .usb_osc_direct_i, .pll_multiplier_field_o, .pll_freq_select_divisor_o, .cpu_en_o,
        .hclk_en_o, .bbus_en_o, .pci_en_o, .lcd_en_o, .ser_en_o, .par_en_o, .mac_rx_en_o,
        .mac_tx_en_o, .usb_pll_bypass_o, .sys_reset_n_o, .change_refused_o);
    pcdt_phy_model i_pcdt_phy_model (.rmii_i(rmii_mode_i), .rx_clk_o(rx_clk_i),
        .tx_clk_o(tx_clk_i), .ext_clk_o(ext_clk_i));
    initial forever #12.5 mclk_i = !mclk_i;
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task summarize;
        $display("mismatches=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cycles between two pulses of one enable, counted at falling edges
    task per(input int b, output int q);
        q = 0;
        while (ens[b] !== 1'b1 && q < 300) begin @(negedge mclk_i); q++; end
        q = 0;
        do begin @(negedge mclk_i); q++; end while (ens[b] !== 1'b1 && q < 300);
    endtask
    task req(input logic [4:0] m, input logic [1:0] f, input logic sr, input logic rm);
        sw_mult_i = m; sw_fs_i = f; sw_change_i = !sr; sw_sys_reset_i = sr;
        @(negedge mclk_i); sw_change_i = 0; sw_sys_reset_i = 0; lo = 0; rf = 0;
        for (int k = 0; k < 400; k++) begin
            if (change_refused_o === 1'b1) rf = 1'b1;
            // Mode flips only inside reset so no stale edge escapes
            if (sys_reset_n_o === 1'b0) begin lo++; rmii_mode_i = rm; end
            else if (k > 3) break;
            @(negedge mclk_i);
        end
    endtask
    task wait_up;
        for (int k = 0; k < 300 && sys_reset_n_o !== 1'b1; k++) @(negedge mclk_i);
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin n_errors++; summarize; end
    end
    initial begin
        repeat (5) @(negedge mclk_i);
        reset_n_i = 1;
        chk(sys_reset_n_o, 0);
        wait_up;
        chk(pll_multiplier_field_o, 15);
        chk(pll_freq_select_divisor_o, PCDT_FS_RESET);
        for (int b = 0; b < 3; b++) begin per(b, p); chk(p, 2 << b); end
        for (int b = 5; b < 7; b++) begin per(b, p); chk(p, 8); end
        for (int i = 0; i < 4; i++) begin
            pci_div_sel_i = 2'(rows[i][0]); lcd_div_sel_i = 2'(rows[i][0]);
            repeat (40) @(negedge mclk_i);
            per(3, p); chk(p, rows[i][1]);
            per(4, p); chk(p, rows[i][2]);
        end
        ext_sel_i = 4'hF;
        repeat (10) @(negedge mclk_i);
        for (int b = 3; b < 7; b++) begin per(b, p); chk(p >= 32 && p <= 33, 1); end
        ext_sel_i = 4'h0;
        per(7, p); chk(p >= 40 && p <= 41, 1);
        per(8, p); chk(p >= 58 && p <= 59, 1);
        for (int i = 0; i < 6; i++) begin
            req(5'(rqs[i][0]), 2'(rqs[i][1]), 1'b0, 1'b0);
            if (rqs[i][2] == 1) begin em = rqs[i][0]; ef = rqs[i][1]; end
            chk(rf, rqs[i][2] == 0);
            chk(lo, rqs[i][2] * 20);
            chk(pll_multiplier_field_o, em);
            chk(pll_freq_select_divisor_o, ef);
        end
        req(5'h00, 2'h0, 1'b1, 1'b1);
        chk(lo, PCDT_SWRST_CYC);
        chk(pll_multiplier_field_o, em);
        per(8, p); chk(p >= 40 && p <= 41, 1);
        chk(usb_pll_bypass_o, 0);
        usb_osc_direct_i = 1;
        repeat (2) @(negedge mclk_i);
        chk(usb_pll_bypass_o, 1);
        strap_mult_i = 5'h0B; reset_n_i = 0;
        @(negedge mclk_i);
        chk({sys_reset_n_o, cpu_en_o}, 0);
        reset_n_i = 1;
        wait_up;
        chk(pll_multiplier_field_o, 11);
        summarize;
    end
endmodule
